// file: design/swrs_top.sv
// Reset sequencer of a packet switch with APB register access
`timescale 1ns/100ps
module swrs_top
  import swrs_pkg::*;
#(
  parameter int LT_CYC = LT_CYC_DEF,
  parameter int CR_CYC = CR_CYC_DEF
)(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        fundamental_reset_in_n,
  input  wire logic        reset_halt,
  input  wire logic        master_twowire_slow_sel,
  input  wire logic [3:0]  slave_twowire_addr_pins,
  input  wire logic [2:0]  switch_operating_mode_pins,
  input  wire logic        pll_serdes_ready,
  input  wire logic        hot_reset_ts1_rx,
  input  wire logic        upstream_dl_down,
  input  wire logic        eep_wr_valid,
  output logic             eep_wr_ready,
  input  wire logic [7:0]  eep_wr_addr,
  input  wire logic [31:0] eep_wr_data,
  input  wire logic        eep_load_done,
  input  wire logic        eep_load_err,
  input  wire logic [3:0]  eep_err_code,
  output logic             eep_load_req,
  output logic             pll_serdes_en,
  output logic             link_train_en,
  output logic             cfg_retry_only,
  output logic             core_run,
  output logic             slv_twowire_en,
  output logic [3:0]       slv_twowire_addr,
  output logic             mst_twowire_en,
  output logic             mst_twowire_tick,
  output logic             phy_retrain,
  output logic             ds_hot_ts1,
  output logic             ds_reg_clear,
  output logic             ds_tlp_discard,
  output logic             ds_port_reset,
  output logic             us_secondary_ur
);
  localparam logic [22:0] LT_N = 23'(LT_CYC);
  localparam logic [22:0] CR_N = 23'(CR_CYC);

  swrs_state_type state_q, state_d;
  logic        hot_q, pin_prev_q, dl_prev_q, ack_q, err_q;
  logic        fund_pend_q, hot_pend_q, boot_halt_q;
  logic        ctl_halt_q, ctl_ldd_q, ctl_hel_q, brg_sbr_q, sts_halt_q;
  logic        tw_done_q, tw_err_q;
  logic [3:0]  tw_code_q;
  logic [2:0]  mode_q, sb_q;
  logic        slow_q;
  logic [7:0]  phy_q;
  logic [22:0] timer_q;
  logic [8:0]  div_q;
  logic        pin_rise, fund_cond, hot_req, in_hot, in_sb, eep_go;
  logic        apb_wr, wr_en;
  logic [7:0]  wa;
  logic [31:0] wd;

  // Address decode shared by reads and writes
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction : hit

  // Register read view; hot reset hides link state and bridge, secondary reset shows the link state default
  function automatic logic [31:0] rd_word(input logic [7:0] a);
    rd_word = 32'h0;
    if (hit(a, ADR_CTRL))
    begin
      rd_word[CTL_HALT] = ctl_halt_q;
      rd_word[CTL_LDD]  = ctl_ldd_q;
      rd_word[CTL_HEL]  = ctl_hel_q;
      rd_word[CTL_SBR]  = brg_sbr_q;
    end
    else if (hit(a, ADR_STAT))
    begin
      rd_word[STS_HALT]            = sts_halt_q;
      rd_word[STS_MODE+:3]         = mode_q;
      rd_word[STS_SLOW]            = slow_q;
      rd_word[STS_ADDR+:4]         = slv_twowire_addr;
      rd_word[STS_STATE+:4]        = state_q;
    end
    else if (hit(a, ADR_TWS))
    begin
      rd_word[TWS_DONE]   = tw_done_q;
      rd_word[TWS_ERR]    = tw_err_q;
      rd_word[TWS_CODE+:4] = tw_code_q;
    end
    else if (hit(a, ADR_PHY) && !in_hot)
      rd_word[7:0] = in_sb ? PHY_RST : phy_q;
    else if (hit(a, ADR_BRG) && !in_hot)
      rd_word[BRG_SBR] = brg_sbr_q;
  endfunction : rd_word

  // Reset conditions and triggers
  assign pin_rise  = fundamental_reset_in_n && !pin_prev_q;
  assign fund_cond = !fundamental_reset_in_n || fund_pend_q;
  assign hot_req   = hot_reset_ts1_rx || hot_pend_q
                   || (upstream_dl_down && !dl_prev_q && !ctl_ldd_q);
  assign in_hot    = (state_q == S_HOT);
  assign in_sb     = (sb_q != SB_IDLE);
  assign eep_go    = (mode_q == MODE_EEPROM) && !(hot_q && ctl_hel_q);

  // APB slave: one wait state, answer registered
  assign apb_wr       = psel && penable && pwrite && ack_q;
  assign eep_wr_ready = !apb_wr;
  assign wr_en        = apb_wr || eep_wr_valid;
  assign wa           = apb_wr ? paddr : eep_wr_addr;
  assign wd           = apb_wr ? pwdata : eep_wr_data;
  assign pready       = ack_q;
  assign pslverr      = ack_q && err_q;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ack_q  <= 1'b0;
      err_q  <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      ack_q <= psel && penable && !ack_q;
      if (psel && penable && !ack_q)
      begin
        err_q  <= !(hit(paddr, ADR_CTRL) || hit(paddr, ADR_STAT) || hit(paddr, ADR_TWS)
                    || hit(paddr, ADR_PHY) || hit(paddr, ADR_BRG));
        prdata <= pwrite ? 32'h0 : rd_word(paddr);
      end
    end
  end

  // Edge history and boot vector sampling at pin release
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pin_prev_q  <= 1'b0;
      dl_prev_q   <= 1'b0;
      mode_q      <= MODE_NORMAL;
      slow_q      <= 1'b0;
      boot_halt_q <= 1'b0;
      slv_twowire_addr <= 4'h0;
    end
    else
    begin
      pin_prev_q <= fundamental_reset_in_n;
      dl_prev_q  <= upstream_dl_down;
      if (pin_rise)
      begin
        mode_q           <= switch_operating_mode_pins;
        slow_q           <= master_twowire_slow_sel;
        boot_halt_q      <= reset_halt;
        slv_twowire_addr <= slave_twowire_addr_pins;
      end
    end
  end

  // Pending triggers start their reset only after the write has completed
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      fund_pend_q <= 1'b0;
      hot_pend_q  <= 1'b0;
    end
    else
    begin
      fund_pend_q <= (apb_wr && hit(wa, ADR_CTRL) && wd[CTL_FUND])
                     || (fund_pend_q && state_q != S_RST);
      hot_pend_q  <= (apb_wr && hit(wa, ADR_CTRL) && wd[CTL_HOT] && !in_hot)
                     || (hot_pend_q && !in_hot);
    end
  end

  // Control bits; fundamental reset clears all but halt, which loads the halt strap; hot reset only non-sticky
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctl_halt_q <= 1'b0;
      ctl_ldd_q  <= 1'b0;
      ctl_hel_q  <= 1'b0;
      brg_sbr_q  <= 1'b0;
      phy_q      <= PHY_RST;
    end
    else if (state_q == S_RST)
    begin
      ctl_halt_q <= pin_rise ? reset_halt : boot_halt_q;
      ctl_ldd_q  <= 1'b0;
      ctl_hel_q  <= 1'b0;
      brg_sbr_q  <= 1'b0;
      phy_q      <= PHY_RST;
    end
    else if (in_hot)
    begin
      ctl_halt_q <= 1'b0;
      brg_sbr_q  <= 1'b0;
      phy_q      <= PHY_RST;
    end
    else
    begin
      if (state_q == S_EEP && eep_load_err)
        ctl_halt_q <= 1'b1;
      else if (wr_en && hit(wa, ADR_CTRL))
        ctl_halt_q <= wd[CTL_HALT];
      if (wr_en && hit(wa, ADR_CTRL))
      begin
        ctl_ldd_q <= wd[CTL_LDD];
        ctl_hel_q <= wd[CTL_HEL];
      end
      if (wr_en && hit(wa, ADR_BRG))
        brg_sbr_q <= wd[BRG_SBR];
      if (wr_en && hit(wa, ADR_PHY) && !in_sb)
        phy_q <= {wd[7:1], 1'b0};
    end
  end

  // Retrain pulse on a write of the retrain bit
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      phy_retrain <= 1'b0;
    else
      phy_retrain <= wr_en && hit(wa, ADR_PHY) && wd[PHY_RETRAIN]
                     && !in_hot && !in_sb && state_q != S_RST;
  end

  // Status flags: hardware set wins over write-one-to-clear
  always_ff @(posedge clk)
  begin
    if (!rst_n || state_q == S_RST)
    begin
      sts_halt_q <= 1'b0;
      tw_done_q  <= 1'b0;
      tw_err_q   <= 1'b0;
      tw_code_q  <= 4'h0;
    end
    else
    begin
      if (state_q == S_TRAIN && !hot_q && reset_halt)
        sts_halt_q <= 1'b1;
      else if (wr_en && hit(wa, ADR_STAT) && wd[STS_HALT])
        sts_halt_q <= 1'b0;
      if (state_q == S_EEP && (eep_load_done || eep_load_err))
        tw_done_q <= 1'b1;
      else if (wr_en && hit(wa, ADR_TWS) && wd[TWS_DONE])
        tw_done_q <= 1'b0;
      if (state_q == S_EEP && eep_load_err)
      begin
        tw_err_q  <= 1'b1;
        tw_code_q <= eep_err_code;
      end
      else if (wr_en && hit(wa, ADR_TWS) && wd[TWS_ERR])
        tw_err_q <= 1'b0;
    end
  end

  // Sequencer next state
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      S_RST:   state_d = S_PLL;
      S_PLL:   if (pll_serdes_ready || timer_q >= LT_N) state_d = S_TRAIN;
      S_TRAIN: state_d = !hot_q ? S_FREQ : (eep_go ? S_EEP : S_HALT);
      S_FREQ:  state_d = S_SLV;
      S_SLV:   state_d = S_MST;
      S_MST:   state_d = eep_go ? S_EEP : S_HALT;
      S_EEP:   if (eep_load_done || eep_load_err) state_d = S_HALT;
      S_HALT:  if (!ctl_halt_q) state_d = S_RUN;
      S_RUN:   state_d = S_RUN;
      S_HOT:   if (!hot_reset_ts1_rx) state_d = S_TRAIN;
    endcase
    if (fund_cond)
      state_d = S_RST;
    else if (hot_req && state_q != S_RST && state_q != S_PLL)
      state_d = S_HOT;
  end

  // Sequencer state and hot flag
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_q <= S_RST;
      hot_q   <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      if (state_d == S_RST)
        hot_q <= 1'b0;
      else if (state_d == S_HOT)
        hot_q <= 1'b1;
    end
  end

  // Time since the reset condition cleared, saturating
  always_ff @(posedge clk)
  begin
    if (!rst_n || state_q == S_RST || in_hot)
      timer_q <= 23'h0;
    else if (timer_q < CR_N)
      timer_q <= timer_q + 23'h1;
  end

  // Two-wire enables survive hot and secondary resets
  always_ff @(posedge clk)
  begin
    if (!rst_n || state_q == S_RST)
    begin
      slv_twowire_en <= 1'b0;
      mst_twowire_en <= 1'b0;
    end
    else
    begin
      if (state_q == S_SLV)
        slv_twowire_en <= 1'b1;
      if (state_q == S_MST)
        mst_twowire_en <= 1'b1;
    end
  end

  // Master bit-rate enable divider
  always_ff @(posedge clk)
  begin
    if (!rst_n || !mst_twowire_en)
    begin
      div_q            <= 9'h0;
      mst_twowire_tick <= 1'b0;
    end
    else
    begin
      div_q            <= (div_q == (slow_q ? DIV_SLOW : DIV_FAST) - 9'h1) ? 9'h0
                          : div_q + 9'h1;
      mst_twowire_tick <= (div_q == 9'h0);
    end
  end

  // Upstream secondary reset steps
  always_ff @(posedge clk)
  begin
    if (!rst_n || state_q == S_RST || in_hot)
      sb_q <= SB_IDLE;
    else
    begin
      unique case (sb_q)
        SB_IDLE: if (brg_sbr_q) sb_q <= SB_TS1;
        SB_TS1:  sb_q <= SB_REGS;
        SB_REGS: sb_q <= SB_DISC;
        SB_DISC: sb_q <= SB_HOLD;
        SB_HOLD: if (!brg_sbr_q) sb_q <= SB_IDLE;
        default: sb_q <= SB_IDLE;
      endcase
    end
  end

  // Sequencer outputs
  assign pll_serdes_en   = (state_q != S_RST);
  assign link_train_en   = !(state_q inside {S_RST, S_PLL, S_HOT});
  assign cfg_retry_only  = !(state_q inside {S_RST, S_PLL, S_HOT, S_RUN});
  assign core_run        = (state_q == S_RUN);
  assign eep_load_req    = (state_q == S_EEP);
  assign ds_hot_ts1      = in_hot || sb_q == SB_TS1;
  assign ds_reg_clear    = (sb_q == SB_REGS);
  assign ds_tlp_discard  = (sb_q == SB_DISC);
  assign ds_port_reset   = in_sb;
  assign us_secondary_ur = in_sb;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_FUND_PIN: assert property (!fundamental_reset_in_n |=> state_q == S_RST)
    else $error("pin reset did not enter reset state");
  AST_BOOT: assert property (pin_rise |=> mode_q == $past(switch_operating_mode_pins))
    else $error("boot mode not sampled at release");
  AST_HALT_STS: assert property (state_q == S_TRAIN && !hot_q && reset_halt
                                 && !fund_cond |=> sts_halt_q)
    else $error("halt status not set");
  AST_TRAIN: assert property ($rose(link_train_en) |-> timer_q <= LT_N + 23'h1)
    else $error("training not started in time");
  AST_SLOW: assert property (mst_twowire_tick && slow_q |=> !mst_twowire_tick [*8])
    else $error("slow divider too fast");
  AST_ORDER: assert property (state_q == S_FREQ && !fund_cond && !hot_req
                              |=> state_q == S_SLV ##1 slv_twowire_en)
    else $error("slave not enabled after frequency step");
  AST_EEP_ERR: assert property (state_q == S_EEP && eep_load_err && !fund_cond && !hot_req
                                |=> ctl_halt_q && tw_done_q && tw_err_q)
    else $error("load error not recorded");
  AST_HALT: assert property (state_q == S_HALT && ctl_halt_q && !fund_cond && !hot_req
                             |=> !core_run)
    else $error("left halt while bit set");
  AST_CPL: assert property (apb_wr && hit(paddr, ADR_CTRL) && pwdata[CTL_FUND]
                            |-> pready ##1 (state_q != S_RST) ##1 (state_q == S_RST))
    else $error("reset began before write completed");
  AST_DLD: assert property (state_q == S_RUN && ctl_ldd_q && !hot_reset_ts1_rx && !hot_pend_q
                            && !fund_cond |=> state_q == S_RUN)
    else $error("link down hot reset not blocked");
  AST_SBR: assert property (sb_q == SB_TS1 && state_q != S_HOT && !fund_cond
                            |=> ds_reg_clear ##1 ds_tlp_discard ##1 ds_port_reset)
    else $error("secondary reset steps out of order");
endmodule : swrs_top

// file: design/swrs_pkg.sv
// Package: register map, field positions, reset values, timing and states of the reset sequencer
package swrs_pkg;
  // Register byte addresses
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STAT = 8'h04;
  localparam logic [7:0] ADR_TWS  = 8'h08;
  localparam logic [7:0] ADR_PHY  = 8'h0C;
  localparam logic [7:0] ADR_BRG  = 8'h10;
  // switch_control_reg fields
  localparam int CTL_FUND = 0;
  localparam int CTL_HOT  = 1;
  localparam int CTL_HALT = 2;
  localparam int CTL_LDD  = 3;
  localparam int CTL_HEL  = 4;
  localparam int CTL_SBR  = 5;
  // switch_status_reg fields
  localparam int STS_HALT  = 0;
  localparam int STS_MODE  = 1;
  localparam int STS_SLOW  = 4;
  localparam int STS_ADDR  = 5;
  localparam int STS_STATE = 12;
  // twowire_status_reg fields
  localparam int TWS_DONE = 0;
  localparam int TWS_ERR  = 1;
  localparam int TWS_CODE = 4;
  // phy_link_state0_reg and bridge_control_reg fields
  localparam int PHY_RETRAIN = 0;
  localparam int BRG_SBR     = 0;
  // Reset values
  localparam logic [7:0] PHY_RST = 8'h00;
  // Operating modes
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_EEPROM = 3'h1;
  // Timing
  localparam int CLK_KHZ     = 50_000;
  localparam int TW_SLOW_KHZ = 100;
  localparam int TW_FAST_KHZ = 400;
  localparam logic [8:0] DIV_SLOW = 9'(CLK_KHZ / TW_SLOW_KHZ);
  localparam logic [8:0] DIV_FAST = 9'(CLK_KHZ / TW_FAST_KHZ);
  localparam int LT_MS      = 20;
  localparam int CR_MS      = 100;
  localparam int LT_CYC_DEF = CLK_KHZ * LT_MS;
  localparam int CR_CYC_DEF = CLK_KHZ * CR_MS;
  // Secondary reset steps
  localparam logic [2:0] SB_IDLE = 3'h0;
  localparam logic [2:0] SB_TS1  = 3'h1;
  localparam logic [2:0] SB_REGS = 3'h2;
  localparam logic [2:0] SB_DISC = 3'h3;
  localparam logic [2:0] SB_HOLD = 3'h4;
  // Sequencer states, Gray coded along the cold path through S_EEP
  typedef enum logic [3:0] {
    S_RST = 4'h0, S_PLL = 4'h1, S_TRAIN = 4'h3, S_FREQ = 4'h2, S_SLV = 4'h6,
    S_MST = 4'h7, S_EEP = 4'h5, S_HALT = 4'h4, S_RUN = 4'hC, S_HOT = 4'hD
  } swrs_state_type;
endpackage : swrs_pkg

// file: sim/swrs_far_model.sv
// Far-side model: PLL and SerDes readiness plus the serial EEPROM loader
`timescale 1ns/100ps
module swrs_far_model (
  input  wire logic        clk,
  input  wire logic        pll_serdes_en,
  output logic             pll_serdes_ready,
  input  wire logic        eep_load_req,
  input  wire logic        inject_err,
  output logic             eep_wr_valid,
  input  wire logic        eep_wr_ready,
  output logic [7:0]       eep_wr_addr,
  output logic [31:0]      eep_wr_data,
  output logic             eep_load_done,
  output logic             eep_load_err,
  output logic [3:0]       eep_err_code
);
  logic [2:0] pcnt_q = 3'h0;

  // Ready comes a few cycles after the enable, drops one cycle after it
  always @(posedge clk)
    if (!pll_serdes_en)
      pcnt_q <= 3'h0;
    else if (pcnt_q != 3'h7)
      pcnt_q <= pcnt_q + 3'h1;
  assign pll_serdes_ready = (pcnt_q == 3'h7);

  // Idle levels at time zero
  initial
  begin
    eep_wr_valid  = 1'b0;
    eep_wr_addr   = 8'h00;
    eep_wr_data   = 32'h0;
    eep_load_done = 1'b0;
    eep_load_err  = 1'b0;
    eep_err_code  = 4'h0;
  end

  localparam logic [7:0] ADR_PHY_C = 8'h0C;

  // One word to the link state register, held until taken
  task automatic wr(input logic [31:0] d);
    eep_wr_valid <= 1'b1;
    eep_wr_addr  <= ADR_PHY_C;
    eep_wr_data  <= d;
    @(posedge clk);
    while (eep_wr_ready !== 1'b1)
      @(posedge clk);
    eep_wr_valid <= 1'b0;
    eep_wr_addr  <= ~ADR_PHY_C;  // Released lines do not keep the word
    eep_wr_data  <= ~d;
    @(posedge clk);
  endtask : wr

  // Loader: either an error at once, or the image then done
  always
  begin
    @(posedge clk);
    if (eep_load_req === 1'b1)
    begin
      if (inject_err)
      begin
        eep_err_code <= 4'h5;
        eep_load_err <= 1'b1;
      end
      else
      begin
        wr(32'h0000_00A4);
        wr(32'h0000_00A5);
        eep_load_done <= 1'b1;
      end
      @(posedge clk);
      eep_load_done <= 1'b0;
      eep_load_err  <= 1'b0;
      @(posedge clk);
    end
  end
endmodule : swrs_far_model

// file: sim/tb_top.sv
// Testbench of the reset sequencer: boot table, then hot and secondary resets
`timescale 1ns/100ps
module tb_top;
  import swrs_pkg::*;
  localparam int LT = 50;
  localparam int CR = 200;
  typedef struct {
    logic        slow;
    logic [3:0]  adr;
    logic [2:0]  mode;
    logic        err;
    int          per;
    logic [31:0] tws;
  } swrs_row_type;
  swrs_row_type rows [4] = '{'{1'b1, 4'h5, 3'h0, 1'b0, 500, 32'h00},
                             '{1'b1, 4'h3, 3'h1, 1'b1, 500, 32'h53},
                             '{1'b0, 4'hF, 3'h0, 1'b0, 125, 32'h00},
                             '{1'b0, 4'hA, 3'h1, 1'b0, 125, 32'h01}};
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, se, eep_wr_ready, eep_load_req, pll_serdes_en, link_train_en;
  logic cfg_retry_only, core_run, slv_twowire_en, mst_twowire_en, mst_twowire_tick;
  logic phy_retrain, ds_hot_ts1, ds_reg_clear, ds_tlp_discard, ds_port_reset;
  logic us_secondary_ur, pll_serdes_ready, eep_wr_valid, eep_load_done, eep_load_err;
  logic [3:0] slv_twowire_addr, eep_err_code;
  logic [7:0] eep_wr_addr;
  logic [31:0] eep_wr_data;
  logic fundamental_reset_in_n = 1'b0, reset_halt = 1'b0, master_twowire_slow_sel = 1'b0;
  logic [3:0] slave_twowire_addr_pins = 4'h0;
  logic [2:0] switch_operating_mode_pins = 3'h0;
  logic hot_reset_ts1_rx = 1'b0, upstream_dl_down = 1'b0, inj = 1'b0;
  int error_cnt = 0, samples_checked = 0, req_cnt = 0, rtr_cnt = 0, q0, ts, tc, td;

  // Clock and the design with shortened training and retry limits
  always #10 clk = ~clk;
  swrs_top #(.LT_CYC(LT), .CR_CYC(CR)) swrs_top_inst (.clk, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .fundamental_reset_in_n,
    .reset_halt, .master_twowire_slow_sel, .slave_twowire_addr_pins,
    .switch_operating_mode_pins, .pll_serdes_ready, .hot_reset_ts1_rx, .upstream_dl_down,
    .eep_wr_valid, .eep_wr_ready, .eep_wr_addr, .eep_wr_data, .eep_load_done,
    .eep_load_err, .eep_err_code, .eep_load_req, .pll_serdes_en, .link_train_en,
    .cfg_retry_only, .core_run, .slv_twowire_en, .slv_twowire_addr, .mst_twowire_en,
    .mst_twowire_tick, .phy_retrain, .ds_hot_ts1, .ds_reg_clear, .ds_tlp_discard,
    .ds_port_reset, .us_secondary_ur);
  swrs_far_model swrs_far_model_inst (.clk, .pll_serdes_en, .pll_serdes_ready,
    .eep_load_req, .inject_err(inj), .eep_wr_valid, .eep_wr_ready, .eep_wr_addr,
    .eep_wr_data, .eep_load_done, .eep_load_err, .eep_err_code);

  // Count loader requests and retrain pulses
  always @(posedge clk)
  begin
    req_cnt <= req_cnt + int'($rose(eep_load_req));
    rtr_cnt <= rtr_cnt + int'(phy_retrain === 1'b1);
  end

  task automatic give_verdict;
    if (error_cnt == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  task automatic cmp_bit(input string n, input logic e, input logic g);
    samples_checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %b seen %b", n, e, g);
    end
  endtask : cmp_bit

  task automatic cmp_word(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : cmp_word

  // One APB transfer; read data and error kept in rd and se
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    cmp_bit("pready", 1'b1, pready);
    rd = prdata;
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wait_run(input int lim);
    int n;
    n = 0;
    while (core_run !== 1'b1 && n < lim)
    begin
      @(posedge clk);
      n++;
    end
  endtask : wait_run

  task automatic tick_period(output int p);
    int n;
    n = 0;
    while (mst_twowire_tick !== 1'b1 && n < 1000)
    begin
      @(posedge clk);
      n++;
    end
    p = 0;
    do
    begin
      @(posedge clk);
      p++;
    end
    while (mst_twowire_tick !== 1'b1 && p < 1000);
  endtask : tick_period

  // Fundamental reset through the pin with one strap set
  task automatic boot(input swrs_row_type r);
    int n, tl, tr, p;
    master_twowire_slow_sel    <= r.slow;
    slave_twowire_addr_pins    <= r.adr;
    switch_operating_mode_pins <= r.mode;
    inj                        <= r.err;
    fundamental_reset_in_n     <= 1'b0;
    repeat (4) @(posedge clk);
    fundamental_reset_in_n <= 1'b1;
    q0 = rtr_cnt;
    n = 0;
    tl = 0;
    tr = 0;
    while (core_run !== 1'b1 && n < 1500)
    begin
      @(posedge clk);
      n++;
      if (link_train_en === 1'b1 && tl == 0)
        tl = n;
      if (cfg_retry_only === 1'b1 && tr == 0)
        tr = n;
    end
    cmp_bit("train_in_time", 1'b1, tl > 0 && tl <= LT);
    cmp_bit("retry_in_time", 1'b1, tr > 0 && tr <= CR);
    cmp_bit("core_run", !r.err, core_run);
    apb(1'b0, ADR_STAT, 32'h0);
    cmp_word("straps", 32'({r.adr, r.slow, r.mode, 1'b0}), rd & 32'h1FE);
    cmp_word("slave_addr", 32'(r.adr), 32'(slv_twowire_addr));
    cmp_bit("slave_en", 1'b1, slv_twowire_en);
    apb(1'b0, ADR_TWS, 32'h0);
    cmp_word("twowire_status", r.tws, rd);
    apb(1'b0, ADR_CTRL, 32'h0);
    cmp_bit("halt_ctl", r.err, rd[CTL_HALT]);
    cmp_word("retrains", 32'(r.mode == 3'h1 && !r.err), 32'(rtr_cnt - q0));
    if (r.err)
    begin
      apb(1'b1, ADR_CTRL, 32'h0);
      wait_run(100);
      cmp_bit("run_after_clear", 1'b1, core_run);
    end
    tick_period(p);
    cmp_word("tick_period", 32'(r.per), 32'(p));
    cmp_bit("master_en", 1'b1, mst_twowire_en);
  endtask : boot

  // Main sequence: boot table, then hot, secondary and halt cases
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (rows[i])
      boot(rows[i]);
    q0 = req_cnt;
    apb(1'b1, ADR_CTRL, 32'h2);
    cmp_bit("run_after_hot_write", 1'b1, core_run);
    repeat (3) @(posedge clk);
    cmp_bit("hot_by_bit", 1'b0, core_run);
    wait_run(1000);
    cmp_word("hot_reload", 32'(q0 + 1), 32'(req_cnt));
    apb(1'b1, ADR_CTRL, 32'h18);
    apb(1'b1, ADR_PHY, 32'h80);
    q0 = req_cnt;
    upstream_dl_down <= 1'b1;
    repeat (4) @(posedge clk);
    cmp_bit("linkdown_blocked", 1'b1, core_run);
    hot_reset_ts1_rx <= 1'b1;
    repeat (4) @(posedge clk);
    cmp_bit("ts1_forward", 1'b1, ds_hot_ts1);
    cmp_bit("pll_kept", 1'b1, pll_serdes_en);
    cmp_bit("twowire_kept", 1'b1, mst_twowire_en);
    apb(1'b0, ADR_PHY, 32'h0);
    cmp_word("phy_in_hot", 32'h0, rd);
    hot_reset_ts1_rx <= 1'b0;
    upstream_dl_down <= 1'b0;
    wait_run(1000);
    apb(1'b0, ADR_CTRL, 32'h0);
    cmp_word("sticky_kept", 32'h18, rd & 32'h18);
    apb(1'b0, ADR_PHY, 32'h0);
    cmp_word("phy_cleared", 32'h0, rd);
    cmp_word("no_reload", 32'(q0), 32'(req_cnt));
    apb(1'b1, ADR_CTRL, 32'h0);
    upstream_dl_down <= 1'b1;
    repeat (3) @(posedge clk);
    cmp_bit("hot_by_linkdown", 1'b0, core_run);
    upstream_dl_down <= 1'b0;
    wait_run(1000);
    // Secondary reset: step order, upstream kept, port held until cleared
    apb(1'b1, ADR_BRG, 32'h1);
    ts = 99;
    tc = 99;
    td = 99;
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk);
      if (ds_hot_ts1 === 1'b1 && ts == 99)
        ts = i;
      if (ds_reg_clear === 1'b1)
        tc = i;
      if (ds_tlp_discard === 1'b1)
        td = i;
    end
    cmp_bit("secondary_order", 1'b1, ts < tc && tc < td);
    cmp_bit("port_reset", 1'b1, ds_port_reset);
    cmp_bit("secondary_ur", 1'b1, us_secondary_ur);
    cmp_bit("upstream_up", 1'b1, core_run);
    apb(1'b1, ADR_PHY, 32'hFE);
    apb(1'b0, ADR_PHY, 32'h0);
    cmp_word("phy_in_secondary", 32'h0, rd);
    apb(1'b1, ADR_BRG, 32'h0);
    repeat (2) @(posedge clk);
    cmp_bit("port_resumed", 1'b0, ds_port_reset);
    apb(1'b0, ADR_PHY, 32'h0);
    cmp_word("phy_write_ignored", 32'hA4, rd);
    apb(1'b0, 8'h14, 32'h0);
    cmp_bit("unmapped_err", 1'b1, se);
    cmp_word("unmapped_data", 32'h0, rd);
    // Bit-triggered fundamental reset keeps the old straps
    master_twowire_slow_sel    <= 1'b1;
    slave_twowire_addr_pins    <= 4'h0;
    switch_operating_mode_pins <= 3'h0;
    q0 = req_cnt;
    apb(1'b1, ADR_CTRL, 32'h1);
    cmp_bit("run_after_fund_write", 1'b1, core_run);
    repeat (3) @(posedge clk);
    cmp_bit("fund_by_bit", 1'b0, core_run);
    wait_run(1500);
    apb(1'b0, ADR_STAT, 32'h0);
    cmp_word("straps_reused", 32'h142, rd & 32'h1FE);
    cmp_word("fund_reload", 32'(q0 + 1), 32'(req_cnt));
    // Halt strap holds the core until software clears it
    reset_halt             <= 1'b1;
    fundamental_reset_in_n <= 1'b0;
    repeat (4) @(posedge clk);
    fundamental_reset_in_n <= 1'b1;
    wait_run(1500);
    cmp_bit("halt_held", 1'b0, core_run);
    apb(1'b0, ADR_STAT, 32'h0);
    cmp_bit("halt_status", 1'b1, rd[STS_HALT]);
    apb(1'b1, ADR_CTRL, 32'h0);
    apb(1'b1, ADR_STAT, 32'h1);
    wait_run(200);
    cmp_bit("halt_released", 1'b1, core_run);
    apb(1'b0, ADR_STAT, 32'h0);
    cmp_bit("halt_status_cleared", 1'b0, rd[STS_HALT]);
    give_verdict();
  end

  // Watchdog against a hang
  initial
  begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
endmodule : tb_top
